/* pbcs_regs.sv */
// basic control and status registers of a 10/100 transceiver
// assumes a management engine on clk_sys issuing single-cycle read and write strobes
// Operation
// R1 - control bit 15 starts soft reset, self-clears
// R2 - soft reset write keeps other bits zero
// R3 - soft reset keeps register values, not straps
// R4 - bit 14 selects loopback, resets zero
// R5 - bit 13 speed, used only without autoneg
// R6 - bit 12 enables autoneg, overrides speed, duplex
// R7 - bit 11 power down; clear autoneg first
// R8 - bit 10 isolates the MII data interface
// R9 - bit 9 restarts autoneg, self-clears
// R10 - bit 8 duplex, used only without autoneg
// R11 - bit 7 enables collision test, resets zero
// R12 - speed, autoneg, duplex reset from mode straps
// R13 - status bits 14 to 11 read one
// R14 - status bits 15, 10, 9, 8 read zero
// R15 - status bits 3 and 0 read one
// R16 - status bit 5 shows autoneg complete
// R17 - status bit 4 latches remote fault high
// R18 - status bit 2 link, latches low
// R19 - status bit 1 latches jabber high
// R20 - latch-high holds until read, then follows
// R21 - latch-low holds zero until register read
// R22 - self-clearing bits ignore zero writes, readable
// R23 - controller writes zeros to reserved fields
// R24 - link stays zero after drop until read
// R25 - reserved bits read zero, ignore writes
`timescale 1ns/1ps
module pbcs_regs
    import pbcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [2:0] mode_strap,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [4:0] reg_idx,
    input wire logic [15:0] wr_data,
    output logic [15:0] rd_data,
    output logic rd_valid,
    input wire logic an_done_in,
    input wire logic remote_fault_in,
    input wire logic link_up_in,
    input wire logic jabber_in,
    input wire logic an_restart_ack,
    output pbcs_cfg_t cfg_out,
    output logic soft_reset_out,
    output logic an_restart_out
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic [6:0] sync1_d;
    logic [6:0] sync2_d;
    logic [2:0] strap_s;
    pbcs_cond_t cond_s;

    // two-stage capture of straps and line conditions
    always_comb begin
        sync1_d = {mode_strap, an_done_in, remote_fault_in, link_up_in, jabber_in};
        sync2_d = sync1_q;
    end

    // no reset here: the straps must already be through both stages when the load state runs
    always_ff @(posedge clk_sys) begin
        if (clk_en) begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    assign strap_s = sync2_q[6:4];
    assign cond_s = sync2_q[3:0];

    // ************************************************************
    // strap capture after hardware reset
    // ************************************************************
    typedef enum logic [1:0] {PBCS_ST_WAIT, PBCS_ST_LOAD, PBCS_ST_RUN} pbcs_state_t;
    pbcs_state_t state_q;
    pbcs_state_t state_d;
    logic [2:0] srst_cnt_q;
    logic [2:0] srst_cnt_d;

    // wait for synchronised straps, load them once, then run
    always_comb begin
        state_d = state_q;
        case (state_q)
            PBCS_ST_WAIT: begin
                state_d = PBCS_ST_LOAD;
            end
            PBCS_ST_LOAD: begin
                state_d = PBCS_ST_RUN;
            end
            PBCS_ST_RUN: begin
                state_d = PBCS_ST_RUN;
            end
            default: begin
                state_d = PBCS_ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= PBCS_ST_WAIT;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // control register
    // ************************************************************
    pbcs_cfg_t cfg_q;
    pbcs_cfg_t cfg_d;
    logic soft_reset_q;
    logic soft_reset_d;
    logic an_restart_q;
    logic an_restart_d;
    logic wr_ctrl;
    logic wr_go;

    assign wr_ctrl = wr_en && (reg_idx == PBCS_IDX_BASIC_CONTROL) && (state_q == PBCS_ST_RUN);
    assign wr_go = wr_ctrl && !soft_reset_q;

    // next control values; soft reset holds config as written
    always_comb begin
        cfg_d = cfg_q;
        soft_reset_d = soft_reset_q;
        an_restart_d = an_restart_q;
        srst_cnt_d = srst_cnt_q;
        if (state_q == PBCS_ST_LOAD) begin
            cfg_d.speed_100 = strap_s[0]; // R12
            cfg_d.duplex_full = strap_s[1]; // R12
            cfg_d.an_enable = strap_s[2]; // R12
        end
        // a soft reset write carries no settings, so the stored config survives it
        if (wr_go && wr_data[PBCS_BIT_SOFT_RESET]) begin
            soft_reset_d = 1'b1; // R1 R3 R22
            srst_cnt_d = PBCS_SRST_CNT_W;
        end else if (wr_go) begin
            // reserved bits 6:0 are not stored
            cfg_d.loopback = wr_data[PBCS_BIT_LOOPBACK]; // R4 R25
            cfg_d.speed_100 = wr_data[PBCS_BIT_SPEED]; // R5
            cfg_d.an_enable = wr_data[PBCS_BIT_AN_ENABLE]; // R6
            cfg_d.power_down = wr_data[PBCS_BIT_POWER_DOWN]; // R7
            cfg_d.isolate = wr_data[PBCS_BIT_ISOLATE]; // R8
            cfg_d.duplex_full = wr_data[PBCS_BIT_DUPLEX]; // R10
            cfg_d.col_test = wr_data[PBCS_BIT_COL_TEST]; // R11
            if (wr_data[PBCS_BIT_AN_RESTART]) begin
                an_restart_d = 1'b1; // R9 R22
            end
        end
        // soft reset runs a fixed count then clears, straps not reloaded
        if (soft_reset_q) begin
            if (srst_cnt_q == 3'h0) begin
                soft_reset_d = 1'b0; // R1 R3
            end else begin
                srst_cnt_d = srst_cnt_q - 3'h1;
            end
        end
        // restart clears once the negotiation engine takes it
        if (an_restart_q && an_restart_ack && !(wr_go && wr_data[PBCS_BIT_AN_RESTART])) begin
            an_restart_d = 1'b0; // R9
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_q <= '{PBCS_RST_LOOPBACK, 1'b0, 1'b0, PBCS_RST_POWER_DOWN,
                       PBCS_RST_ISOLATE, 1'b0, PBCS_RST_COL_TEST};
            soft_reset_q <= 1'b0;
            an_restart_q <= 1'b0;
            srst_cnt_q <= 3'h0;
        end else if (clk_en) begin
            cfg_q <= cfg_d;
            soft_reset_q <= soft_reset_d;
            an_restart_q <= an_restart_d;
            srst_cnt_q <= srst_cnt_d;
        end
    end

    // ************************************************************
    // latched status flags
    // ************************************************************
    logic rf_q;
    logic rf_d;
    logic jab_q;
    logic jab_d;
    logic link_q;
    logic link_d;
    logic link_held_q;
    logic link_held_d;
    logic rd_stat;

    assign rd_stat = rd_en && (reg_idx == PBCS_IDX_BASIC_STATUS);

    // latch-high and latch-low update; the event beats the read release
    always_comb begin
        rf_d = rf_q | cond_s.remote_fault; // R17 R20
        jab_d = jab_q | cond_s.jabber; // R19 R20
        if (rd_stat) begin
            rf_d = cond_s.remote_fault; // R20
            jab_d = cond_s.jabber; // R20
        end
        link_held_d = link_held_q;
        link_d = cond_s.link_up;
        if (!cond_s.link_up) begin
            link_held_d = 1'b1; // R18 R21
        end else if (rd_stat) begin
            link_held_d = 1'b0; // R21 R24
        end
        if (link_held_q && !(rd_stat && cond_s.link_up)) begin
            link_d = 1'b0; // R24
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rf_q <= PBCS_RST_FLAG;
            jab_q <= PBCS_RST_FLAG;
            link_q <= PBCS_RST_FLAG;
            link_held_q <= 1'b1;
        end else if (clk_en) begin
            rf_q <= rf_d;
            jab_q <= jab_d;
            link_q <= link_d;
            link_held_q <= link_held_d;
        end
    end

    // ************************************************************
    // read path and outputs
    // ************************************************************
    logic [15:0] rd_data_d;
    logic [15:0] rd_data_q;
    logic rd_valid_q;
    pbcs_cfg_t cfg_eff_d;
    pbcs_cfg_t cfg_eff_q;
    logic soft_reset_o_q;
    logic an_restart_o_q;

    // read word assembly and effective configuration
    always_comb begin
        rd_data_d = 16'h0000; // R25
        if (reg_idx == PBCS_IDX_BASIC_CONTROL) begin
            rd_data_d[PBCS_BIT_SOFT_RESET] = soft_reset_q;
            rd_data_d[PBCS_BIT_LOOPBACK] = cfg_q.loopback;
            rd_data_d[PBCS_BIT_SPEED] = cfg_q.speed_100;
            rd_data_d[PBCS_BIT_AN_ENABLE] = cfg_q.an_enable;
            rd_data_d[PBCS_BIT_POWER_DOWN] = cfg_q.power_down;
            rd_data_d[PBCS_BIT_ISOLATE] = cfg_q.isolate;
            rd_data_d[PBCS_BIT_AN_RESTART] = an_restart_q;
            rd_data_d[PBCS_BIT_DUPLEX] = cfg_q.duplex_full;
            rd_data_d[PBCS_BIT_COL_TEST] = cfg_q.col_test;
        end else if (reg_idx == PBCS_IDX_BASIC_STATUS) begin
            rd_data_d = PBCS_STATUS_FIXED; // R13 R14 R15
            rd_data_d[PBCS_BIT_AN_DONE] = cond_s.an_done; // R16
            rd_data_d[PBCS_BIT_REMOTE_FAULT] = rf_q; // R17
            rd_data_d[PBCS_BIT_LINK] = link_q; // R18
            rd_data_d[PBCS_BIT_JABBER] = jab_q; // R19
        end
        cfg_eff_d = cfg_q;
        if (cfg_q.an_enable) begin
            cfg_eff_d.speed_100 = 1'b1; // R6 R5 R10
            cfg_eff_d.duplex_full = 1'b1; // R6
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_data_q <= 16'h0000;
            rd_valid_q <= 1'b0;
            cfg_eff_q <= '0;
            soft_reset_o_q <= 1'b0;
            an_restart_o_q <= 1'b0;
        end else if (clk_en) begin
            rd_data_q <= rd_en ? rd_data_d : rd_data_q;
            rd_valid_q <= rd_en;
            cfg_eff_q <= cfg_eff_d;
            soft_reset_o_q <= soft_reset_q;
            an_restart_o_q <= an_restart_q;
        end
    end

    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign cfg_out = cfg_eff_q;
    assign soft_reset_out = soft_reset_o_q;
    assign an_restart_out = an_restart_o_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence srst_write_s;
        clk_en && wr_go && wr_data[PBCS_BIT_SOFT_RESET];
    endsequence

    soft_rst_clear_a: assert property (srst_write_s |=> (soft_reset_q && clk_en) [*5] ##1 !soft_reset_q) // R1
        else $error("soft reset did not clear");
    rst_keeps_cfg_a: assert property (clk_en && soft_reset_q && !wr_go |=> $stable(cfg_q)) // R3
        else $error("config changed during soft reset");
    status_fixed_a: assert property (rd_en && reg_idx == PBCS_IDX_BASIC_STATUS && clk_en |=> // R13
        (rd_data[15:8] == 8'h78) && rd_data[3] && rd_data[0] && !rd_data[7] && !rd_data[6])
        else $error("fixed status bits wrong");
    ctrl_rsvd_a: assert property (rd_en && reg_idx == PBCS_IDX_BASIC_CONTROL && clk_en |=> // R25
        rd_data[6:0] == 7'h00)
        else $error("reserved control bits not zero");
    an_override_a: assert property (cfg_q.an_enable && clk_en |=> cfg_out.speed_100 && cfg_out.duplex_full) // R6
        else $error("autoneg did not override");
    fault_hold_a: assert property (rf_q && !rd_stat && clk_en |=> rf_q) // R20
        else $error("remote fault latch lost");
    jab_follow_a: assert property (rd_stat && clk_en && !cond_s.jabber |=> !jab_q) // R19
        else $error("jabber latch not released");
    link_low_a: assert property (clk_en && !cond_s.link_up |=> !link_q [*1] ##0 link_held_q) // R24
        else $error("link drop not latched");
    restart_hold_a: assert property (clk_en && an_restart_q && !an_restart_ack |=> an_restart_q) // R9
        else $error("restart cleared early");
    loop_wr_a: assert property (clk_en && wr_go && !wr_data[PBCS_BIT_SOFT_RESET] |=> // R4
        cfg_q.loopback == $past(wr_data[PBCS_BIT_LOOPBACK]))
        else $error("loopback not written");
    srst_keep_a: assert property (srst_write_s |=> $stable(cfg_q)) // R3
        else $error("soft reset write changed config");
    restart_set_a: assert property (clk_en && wr_go && wr_data[PBCS_BIT_AN_RESTART] && // R9
        !wr_data[PBCS_BIT_SOFT_RESET] |=> an_restart_q)
        else $error("restart bit not set");
    link_release_a: assert property (rd_stat && clk_en && cond_s.link_up |=> link_q) // R21
        else $error("link latch not released");
    an_done_rd_a: assert property (rd_stat && clk_en |=> // R16
        rd_data[PBCS_BIT_AN_DONE] == $past(cond_s.an_done))
        else $error("autoneg complete bit wrong");
    jab_hold_a: assert property (jab_q && !rd_stat && clk_en |=> jab_q) // R19
        else $error("jabber latch lost");
endmodule

/* pbcs_pkg.sv */
// package for the basic control and status register pair
// assumes a 16-bit management access port with a 5-bit register index
package pbcs_pkg;
    // ************************************************************
    // register indices and field positions
    // ************************************************************
    localparam logic [4:0] PBCS_IDX_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] PBCS_IDX_BASIC_STATUS = 5'h01;
    localparam int PBCS_BIT_SOFT_RESET = 15;
    localparam int PBCS_BIT_LOOPBACK = 14;
    localparam int PBCS_BIT_SPEED = 13;
    localparam int PBCS_BIT_AN_ENABLE = 12;
    localparam int PBCS_BIT_POWER_DOWN = 11;
    localparam int PBCS_BIT_ISOLATE = 10;
    localparam int PBCS_BIT_AN_RESTART = 9;
    localparam int PBCS_BIT_DUPLEX = 8;
    localparam int PBCS_BIT_COL_TEST = 7;
    localparam int PBCS_BIT_AN_DONE = 5;
    localparam int PBCS_BIT_REMOTE_FAULT = 4;
    localparam int PBCS_BIT_LINK = 2;
    localparam int PBCS_BIT_JABBER = 1;
    // fixed ability bits of the status word
    localparam logic [15:0] PBCS_STATUS_FIXED = 16'h7809;
    // ************************************************************
    // values after reset and timing
    // ************************************************************
    localparam logic PBCS_RST_LOOPBACK = 1'b0;
    localparam logic PBCS_RST_POWER_DOWN = 1'b0;
    localparam logic PBCS_RST_ISOLATE = 1'b0;
    localparam logic PBCS_RST_COL_TEST = 1'b0;
    localparam logic PBCS_RST_FLAG = 1'b0;
    localparam int PBCS_SRST_CYCLES = 4;
    localparam logic [2:0] PBCS_SRST_CNT_W = 3'h4;
    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic an_enable;
        logic power_down;
        logic isolate;
        logic duplex_full;
        logic col_test;
    } pbcs_cfg_t;
    typedef struct packed {
        logic an_done;
        logic remote_fault;
        logic link_up;
        logic jabber;
    } pbcs_cond_t;
endpackage

/* pbcs_an_model.sv */
// partner: negotiation engine answering restart requests
// assumes the register block's clock and synchronous reset
`timescale 1ns/1ps
module pbcs_an_model #(
    parameter int ACK_DLY = 3
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic restart_req,
    output logic restart_ack
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    // count request cycles, saturating, so the ack is not instant
    always_comb begin
        cnt_d = restart_req ? cnt_q + 4'h1 : 4'h0;
        if (cnt_q == 4'hF) begin
            cnt_d = cnt_q;
        end
    end
    // register the count only
    always_ff @(posedge clk_sys) begin
        cnt_q <= srst ? 4'h0 : cnt_d;
    end
    // ack held until the request drops
    assign restart_ack = restart_req && (cnt_q >= 4'(ACK_DLY));
endmodule

/* phy_basic_control_status_regs_tb_top.sv */
// testbench of the basic control and status registers
// assumes pbcs_pkg and the negotiation partner model are compiled first
`timescale 1ns/1ps
module phy_basic_control_status_regs_tb_top;
    import pbcs_pkg::*;
    typedef struct {
        logic [15:0] wr;
        logic [15:0] rd;
        logic [6:0] cfg;
    } pbcs_row_t;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic [2:0] mode_strap = 3'h3;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [4:0] reg_idx = 5'h00;
    logic [15:0] wr_data = 16'h0000;
    logic [15:0] rd_data;
    logic rd_valid;
    logic an_done_in = 1'b0;
    logic remote_fault_in = 1'b0;
    logic link_up_in = 1'b0;
    logic jabber_in = 1'b0;
    logic an_restart_ack;
    pbcs_cfg_t cfg_out;
    logic soft_reset_out;
    logic an_restart_out;
    int miscompares = 0;
    int cmp_count = 0;
    // write value, control readback, config seen at the outputs
    pbcs_row_t rows [10] = '{'{16'h4000, 16'h4000, 7'h40}, '{16'h2000, 16'h2000, 7'h20},
        '{16'h0100, 16'h0100, 7'h02}, '{16'h0800, 16'h0800, 7'h08},
        '{16'h0400, 16'h0400, 7'h04}, '{16'h0080, 16'h0080, 7'h01},
        '{16'h007F, 16'h0000, 7'h00}, '{16'h1000, 16'h1000, 7'h32},
        '{16'h3100, 16'h3100, 7'h32}, '{16'h0000, 16'h0000, 7'h00}};

    pbcs_regs i_dut (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .mode_strap(mode_strap),
        .wr_en(wr_en), .rd_en(rd_en), .reg_idx(reg_idx), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid), .an_done_in(an_done_in),
        .remote_fault_in(remote_fault_in), .link_up_in(link_up_in), .jabber_in(jabber_in),
        .an_restart_ack(an_restart_ack), .cfg_out(cfg_out),
        .soft_reset_out(soft_reset_out), .an_restart_out(an_restart_out));
    pbcs_an_model i_an (.clk_sys(clk_sys), .srst(srst), .restart_req(an_restart_out),
        .restart_ack(an_restart_ack));

    // ************************************************************
    // clock, tasks and closing
    // ************************************************************
    // free-running 100 MHz clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // n edges, then settle 1 ns past the last
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input logic [4:0] idx, input logic [15:0] d);
        tick(1);
        wr_en = 1'b1;
        reg_idx = idx;
        wr_data = d;
        tick(1);
        wr_en = 1'b0;
    endtask
    // one-cycle read strobe, data taken with rd_valid
    task automatic rd_chk(input logic [4:0] idx, input logic [15:0] exp, input string what);
        int n;
        tick(1);
        rd_en = 1'b1;
        reg_idx = idx;
        tick(1);
        rd_en = 1'b0;
        n = 0;
        while (rd_valid !== 1'b1 && n < 4) begin
            tick(1);
            n++;
        end
        chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
        chk(what, exp, rd_data);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watchdog cuts a hang short
    initial begin
        #100000;
        miscompares++;
        $display("ERROR watchdog expected end seen timeout");
        tally_and_finish();
    end

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        tick(8);
        srst = 1'b0;
        tick(6);
        rd_chk(PBCS_IDX_BASIC_CONTROL, 16'h2100, "ctrl reset");
        chk("cfg reset", 16'h0022, {9'h000, cfg_out});
        rd_chk(PBCS_IDX_BASIC_STATUS, 16'h7809, "status reset");
        $display("test reset done");
        // ordinary control writes, one row each
        foreach (rows[i]) begin
            wr_reg(PBCS_IDX_BASIC_CONTROL, rows[i].wr);
            rd_chk(PBCS_IDX_BASIC_CONTROL, rows[i].rd, "ctrl row");
            chk("cfg row", {9'h000, rows[i].cfg}, {9'h000, cfg_out});
        end
        $display("test rows done");
        // restart bit clears itself once the engine answers
        wr_reg(PBCS_IDX_BASIC_CONTROL, 16'h1200);
        tick(1);
        chk("restart out", 16'h0001, {15'h0000, an_restart_out});
        tick(10);
        rd_chk(PBCS_IDX_BASIC_CONTROL, 16'h1000, "restart cleared");
        $display("test restart done");
        // soft reset keeps register config, straps changed meanwhile
        wr_reg(PBCS_IDX_BASIC_CONTROL, 16'h4100);
        mode_strap = 3'h4;
        wr_reg(PBCS_IDX_BASIC_CONTROL, 16'h8000);
        tick(1);
        chk("soft reset on", 16'h0001, {15'h0000, soft_reset_out});
        tick(8);
        chk("soft reset off", 16'h0000, {15'h0000, soft_reset_out});
        rd_chk(PBCS_IDX_BASIC_CONTROL, 16'h4100, "ctrl kept");
        $display("test soft reset done");
        // latch-high flags: jabber pulses, remote fault stays
        remote_fault_in = 1'b1;
        jabber_in = 1'b1;
        tick(5);
        jabber_in = 1'b0;
        tick(5);
        rd_chk(PBCS_IDX_BASIC_STATUS, 16'h781B, "flags latched");
        rd_chk(PBCS_IDX_BASIC_STATUS, 16'h7819, "flags follow");
        remote_fault_in = 1'b0;
        tick(5);
        rd_chk(PBCS_IDX_BASIC_STATUS, 16'h7819, "fault held");
        rd_chk(PBCS_IDX_BASIC_STATUS, 16'h7809, "flags clear");
        $display("test latch high done");
        // latch-low link with negotiation complete
        an_done_in = 1'b1;
        link_up_in = 1'b1;
        tick(5);
        rd_chk(PBCS_IDX_BASIC_STATUS, 16'h7829, "link held");
        rd_chk(PBCS_IDX_BASIC_STATUS, 16'h782D, "link up");
        link_up_in = 1'b0;
        tick(5);
        link_up_in = 1'b1;
        tick(5);
        rd_chk(PBCS_IDX_BASIC_STATUS, 16'h7829, "link drop held");
        rd_chk(PBCS_IDX_BASIC_STATUS, 16'h782D, "link back");
        $display("test latch low done");
        // clock enable low freezes everything, writes included
        clk_en = 1'b0;
        wr_reg(PBCS_IDX_BASIC_CONTROL, 16'h0000);
        tick(2);
        chk("frozen cfg", 16'h0042, {9'h000, cfg_out});
        clk_en = 1'b1;
        rd_chk(PBCS_IDX_BASIC_CONTROL, 16'h4100, "ctrl frozen");
        $display("test clock enable done");
        // unmapped index reads zero and ignores writes
        wr_reg(5'h02, 16'hFFFF);
        rd_chk(5'h02, 16'h0000, "unmapped");
        rd_chk(PBCS_IDX_BASIC_CONTROL, 16'h4100, "ctrl untouched");
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule
